// *** pod_pkg.sv ***
package pod_pkg;

    // ------------------------------------------------------------
    // Prefix bytes
    // ------------------------------------------------------------
    localparam logic [7:0] PREFIX_SECOND = 8'h42;
    localparam logic [7:0] PREFIX_THIRD = 8'h89;

    // ------------------------------------------------------------
    // Accumulator column layout, shared by all maps
    // ------------------------------------------------------------
    localparam logic [3:0] COL_IND_X = 4'h1;
    localparam logic [3:0] COL_IND = 4'h2;
    localparam logic [3:0] COL_SR = 4'h3;
    localparam logic [3:0] COL_DIR = 4'h5;
    localparam logic [3:0] COL_LDIR = 4'h7;
    localparam logic [3:0] COL_IMM = 4'h9;
    localparam logic [3:0] COL_ABS = 4'hD;
    localparam logic [3:0] COL_ABL = 4'hF;

    // ------------------------------------------------------------
    // Primary map positions
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_EMPTY_PRI = 8'h02;
    localparam logic [7:0] OPC_BLK_DOWN = 8'h44;
    localparam logic [7:0] OPC_BLK_UP = 8'h54;
    localparam logic [7:0] OPC_BBS_DIR = 8'h24;
    localparam logic [7:0] OPC_BBC_DIR = 8'h34;
    localparam logic [7:0] OPC_BBS_ABS = 8'h2C;
    localparam logic [7:0] OPC_BBC_ABS = 8'h3C;
    localparam logic [7:0] OPC_CLR_STAT = 8'hC2;
    localparam logic [7:0] OPC_SET_STAT = 8'hE2;

    // ------------------------------------------------------------
    // Secondary map positions
    // ------------------------------------------------------------
    localparam logic [7:0] SEC_STORE_IMM = 8'h89;
    localparam logic [7:0] SEC_PUSH = 8'h48;
    localparam logic [7:0] SEC_PULL = 8'h68;
    localparam logic [7:0] SEC_X_TO_B = 8'h8A;
    localparam logic [7:0] SEC_Y_TO_B = 8'h98;
    localparam logic [7:0] SEC_B_TO_Y = 8'hA8;
    localparam logic [7:0] SEC_B_TO_X = 8'hAA;
    localparam logic [7:0] SEC_B_TO_S = 8'h1B;
    localparam logic [7:0] SEC_S_TO_B = 8'h3B;
    localparam logic [7:0] SEC_B_TO_D = 8'h5B;
    localparam logic [7:0] SEC_D_TO_B = 8'h7B;
    localparam logic [3:0] SEC_UNARY_COL = 4'hA;
    localparam logic [3:0] SEC_UNARY_LAST = 4'h4;
    localparam logic [3:0] SEC_UNARY_ROR = 4'h6;

    // ------------------------------------------------------------
    // Tertiary map positions
    // ------------------------------------------------------------
    localparam logic [3:0] TER_LAST_ROW = 4'h3;
    localparam logic [7:0] TER_SWAP = 8'h28;
    localparam logic [7:0] TER_ROTATE = 8'h49;
    localparam logic [7:0] TER_LOAD_BANK = 8'hC2;

    localparam logic [2:0] ROW_PAIR_STORE = 3'h4;

    typedef enum {
        st_first, st_second, st_third
    } pod_state_t;

    typedef enum logic [1:0] {
        map_primary, map_second, map_third
    } pod_map_t;

    typedef enum logic [4:0] {
        op_other, op_or, op_and, op_xor, op_add, op_store, op_load,
        op_compare, op_subtract, op_unary_b, op_move_to_b, op_move_from_b,
        multiply_op, divide_op, swap_accumulators_op,
        rotate_left_by_count_op, load_bank_immediate_op,
        clear_status_bits_op, set_status_bits_op, block_move_down_op,
        block_move_up_op, branch_bits_set_op, branch_bits_clear_op,
        push_second_acc_op, pull_second_acc_op
    } pod_op_t;

    typedef enum logic [4:0] {
        mode_none, mode_imp, mode_imm, mode_acc, mode_stk, mode_dir,
        mode_dir_x, mode_ind, mode_ind_x, mode_ind_y, mode_ldir,
        mode_ldir_y, mode_abs, mode_abs_x, mode_abs_y, mode_abl,
        mode_abl_x, mode_sr, mode_sr_ind_y, mode_blk, mode_dir_bit_rel,
        mode_abs_bit_rel
    } pod_mode_t;

    typedef enum logic [2:0] {
        xfer_none, xfer_x, xfer_y, xfer_stack, xfer_direct_page_base
    } pod_xfer_t;

endpackage

// *** pod_col_mode.sv ***
`timescale 1ns/1ps

module pod_col_mode (
    input wire logic [3:0] col_i,
    input wire logic row_odd_i,
    output pod_pkg::pod_mode_t mode_o,
    output logic valid_o
);
    import pod_pkg::*;

    always_comb begin
        mode_o = mode_none;
        valid_o = 1'b1;
        case (col_i)
            COL_IND_X: mode_o = row_odd_i ? mode_ind_y : mode_ind_x;
            COL_IND: begin
                mode_o = row_odd_i ? mode_ind : mode_none;
                valid_o = row_odd_i;
            end
            COL_SR: mode_o = row_odd_i ? mode_sr_ind_y : mode_sr;
            COL_DIR: mode_o = row_odd_i ? mode_dir_x : mode_dir;
            COL_LDIR: mode_o = row_odd_i ? mode_ldir_y : mode_ldir;
            COL_IMM: mode_o = row_odd_i ? mode_abs_y : mode_imm;
            COL_ABS: mode_o = row_odd_i ? mode_abs_x : mode_abs;
            COL_ABL: mode_o = row_odd_i ? mode_abl_x : mode_abl;
            default: valid_o = 1'b0;
        endcase
    end

endmodule

// *** pod_decoder.sv ***
`timescale 1ns/1ps

module pod_decoder (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic data_len_8bit_i,
    input wire logic [7:0] direct_page_base_low_i,
    output logic decode_valid_o,
    output logic [7:0] opcode_o,
    output pod_pkg::pod_map_t map_o,
    output pod_pkg::pod_op_t op_o,
    output pod_pkg::pod_mode_t mode_o,
    output pod_pkg::pod_xfer_t xfer_reg_o,
    output logic acc_b_o,
    output logic acc_wide_o,
    output logic extra_cycle_o,
    output logic undefined_o,
    output logic prefix_pending_o
);
    import pod_pkg::*;

    // ------------------------------------------------------------
    // Opcode split and column decode
    // ------------------------------------------------------------
    pod_state_t state;
    logic [3:0] row, col;
    pod_mode_t col_mode, next_mode;
    pod_op_t row_op, next_op;
    pod_xfer_t next_xfer;
    pod_map_t next_map;
    logic col_acc, is_prefix, dp_based;
    logic next_acc_b, next_acc_data, next_undef;

    assign row = byte_i[7:4];
    assign col = byte_i[3:0];
    assign is_prefix = (state == st_first)
        && ((byte_i == PREFIX_SECOND) || (byte_i == PREFIX_THIRD));

    pod_col_mode u_col_mode (
        .col_i(col),
        .row_odd_i(row[0]),
        .mode_o(col_mode),
        .valid_o(col_acc)
    );

    always_comb begin
        case (row[3:1])
            3'h0: row_op = op_or;
            3'h1: row_op = op_and;
            3'h2: row_op = op_xor;
            3'h3: row_op = op_add;
            ROW_PAIR_STORE: row_op = op_store;
            3'h5: row_op = op_load;
            3'h6: row_op = op_compare;
            default: row_op = op_subtract;
        endcase
    end

    // ------------------------------------------------------------
    // Map decode
    // ------------------------------------------------------------
    always_comb begin
        next_op = op_other;
        next_mode = mode_none;
        next_xfer = xfer_none;
        next_map = map_primary;
        next_acc_b = 1'b0;
        next_acc_data = 1'b0;
        next_undef = 1'b0;
        case (state)
            st_first: begin
                if (col_acc) begin
                    next_op = row_op;
                    next_mode = col_mode;
                    next_acc_data = 1'b1;
                end else begin
                    case (byte_i)
                        OPC_EMPTY_PRI: next_undef = 1'b1;
                        OPC_BLK_DOWN: next_op = block_move_down_op;
                        OPC_BLK_UP: next_op = block_move_up_op;
                        OPC_BBS_DIR, OPC_BBS_ABS:
                            next_op = branch_bits_set_op;
                        OPC_BBC_DIR, OPC_BBC_ABS:
                            next_op = branch_bits_clear_op;
                        OPC_CLR_STAT: next_op = clear_status_bits_op;
                        OPC_SET_STAT: next_op = set_status_bits_op;
                        // Remaining primary cells are passed on undetailed
                        default: next_op = op_other;
                    endcase
                    case (byte_i)
                        OPC_BLK_DOWN, OPC_BLK_UP: next_mode = mode_blk;
                        OPC_BBS_DIR, OPC_BBC_DIR:
                            next_mode = mode_dir_bit_rel;
                        OPC_BBS_ABS, OPC_BBC_ABS:
                            next_mode = mode_abs_bit_rel;
                        OPC_CLR_STAT, OPC_SET_STAT:
                            next_mode = mode_imm;
                        default: next_mode = mode_none;
                    endcase
                end
            end
            st_second: begin
                next_map = map_second;
                next_acc_b = 1'b1;
                if (col_acc && (byte_i != SEC_STORE_IMM)) begin
                    next_op = row_op;
                    next_mode = col_mode;
                    next_acc_data = 1'b1;
                end else begin
                    next_mode = mode_imp;
                    case (byte_i)
                        SEC_PUSH: begin
                            next_op = push_second_acc_op;
                            next_mode = mode_stk;
                        end
                        SEC_PULL: begin
                            next_op = pull_second_acc_op;
                            next_mode = mode_stk;
                        end
                        SEC_X_TO_B, SEC_Y_TO_B, SEC_S_TO_B, SEC_D_TO_B:
                            next_op = op_move_to_b;
                        SEC_B_TO_X, SEC_B_TO_Y, SEC_B_TO_S, SEC_B_TO_D:
                            next_op = op_move_from_b;
                        default: begin
                            if ((col == SEC_UNARY_COL)
                                && ((row <= SEC_UNARY_LAST)
                                || (row == SEC_UNARY_ROR))) begin
                                next_op = op_unary_b;
                                next_mode = mode_acc;
                                next_acc_data = 1'b1;
                            end else begin
                                next_mode = mode_none;
                                next_undef = 1'b1;
                            end
                        end
                    endcase
                    case (byte_i)
                        SEC_X_TO_B, SEC_B_TO_X: next_xfer = xfer_x;
                        SEC_Y_TO_B, SEC_B_TO_Y: next_xfer = xfer_y;
                        SEC_S_TO_B, SEC_B_TO_S: next_xfer = xfer_stack;
                        SEC_D_TO_B, SEC_B_TO_D:
                            next_xfer = xfer_direct_page_base;
                        default: next_xfer = xfer_none;
                    endcase
                end
            end
            st_third: begin
                next_map = map_third;
                if (col_acc && (row <= TER_LAST_ROW)) begin
                    next_op = row[1] ? divide_op : multiply_op;
                    next_mode = col_mode;
                end else begin
                    next_mode = mode_imm;
                    case (byte_i)
                        TER_SWAP: begin
                            next_op = swap_accumulators_op;
                            next_mode = mode_imp;
                        end
                        TER_ROTATE: next_op = rotate_left_by_count_op;
                        TER_LOAD_BANK: next_op = load_bank_immediate_op;
                        default: begin
                            next_mode = mode_none;
                            next_undef = 1'b1;
                        end
                    endcase
                end
            end
            default: next_undef = 1'b1;
        endcase
    end

    assign dp_based = next_mode inside {mode_dir, mode_dir_x, mode_ind,
        mode_ind_x, mode_ind_y, mode_ldir, mode_ldir_y, mode_dir_bit_rel};

    // ------------------------------------------------------------
    // Prefix sequencing
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state <= st_first;
        end else if (byte_valid_i) begin
            case (state)
                st_first: begin
                    if (byte_i == PREFIX_SECOND) begin
                        state <= st_second;
                    end else if (byte_i == PREFIX_THIRD) begin
                        state <= st_third;
                    end
                end
                default: state <= st_first;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registered decode result
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            decode_valid_o <= 1'b0;
            prefix_pending_o <= 1'b0;
            opcode_o <= 8'h00;
            map_o <= map_primary;
            op_o <= op_other;
            mode_o <= mode_none;
            xfer_reg_o <= xfer_none;
            acc_b_o <= 1'b0;
            acc_wide_o <= 1'b0;
            extra_cycle_o <= 1'b0;
            undefined_o <= 1'b0;
        end else begin
            decode_valid_o <= byte_valid_i && !is_prefix;
            if (byte_valid_i) begin
                prefix_pending_o <= is_prefix;
            end
            if (byte_valid_i && !is_prefix) begin
                opcode_o <= byte_i;
                map_o <= next_map;
                op_o <= next_op;
                mode_o <= next_mode;
                xfer_reg_o <= next_xfer;
                acc_b_o <= next_acc_b;
                // Byte width leaves the upper half of the accumulator alone
                acc_wide_o <= next_acc_data && !data_len_8bit_i;
                extra_cycle_o <= dp_based
                    && (direct_page_base_low_i != 8'h00);
                undefined_o <= next_undef;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    prefix_second_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        byte_valid_i && state == st_first && byte_i == PREFIX_SECOND
        |=> state == st_second && !decode_valid_o)
        else $error("secondary prefix not taken");
    second_map_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        byte_valid_i && state == st_second
        |=> decode_valid_o && map_o == map_second && state == st_first)
        else $error("secondary map not used");
    third_map_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        byte_valid_i && state == st_first && byte_i == PREFIX_THIRD
        ##1 byte_valid_i |=> decode_valid_o && map_o == map_third)
        else $error("tertiary map not used");
    b_target_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        decode_valid_o && !undefined_o |-> acc_b_o == (map_o == map_second))
        else $error("accumulator B target wrong");
    swap_decode_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        byte_valid_i && state == st_third && byte_i == TER_SWAP
        |=> op_o == swap_accumulators_op && !undefined_o)
        else $error("swap not decoded");
    block_move_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        byte_valid_i && state == st_first && byte_i == OPC_BLK_UP
        |=> op_o == block_move_up_op && mode_o == mode_blk)
        else $error("block move not decoded");
    bit_branch_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        decode_valid_o && (op_o == branch_bits_set_op
        || op_o == branch_bits_clear_op)
        |-> (mode_o == mode_dir_bit_rel) == !opcode_o[3])
        else $error("bit branch mode wrong");
    stack_rel_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        decode_valid_o && !undefined_o && opcode_o[3:0] == COL_SR
        |-> mode_o == (opcode_o[4] ? mode_sr_ind_y : mode_sr))
        else $error("stack relative mode wrong");
    status_imm_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        byte_valid_i && state == st_first && byte_i == OPC_SET_STAT
        |=> op_o == set_status_bits_op && mode_o == mode_imm)
        else $error("status set not immediate");
    wide_acc_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        decode_valid_o && acc_wide_o |-> !$past(data_len_8bit_i))
        else $error("wide accumulator in byte mode");
    dp_extra_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        decode_valid_o && mode_o == mode_dir
        |-> extra_cycle_o == ($past(direct_page_base_low_i) != 8'h00))
        else $error("direct page extra cycle wrong");
    empty_flag_a: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        byte_valid_i && state == st_first && byte_i == OPC_EMPTY_PRI
        |=> decode_valid_o && undefined_o)
        else $error("empty cell not flagged");

endmodule

// *** pod_fetch_model.sv ***
`timescale 1ns/1ps

// ------------------------------------------------------------
// Fetch path stand-in: offers opcode bytes with data width and direct page base low, no operands
// ------------------------------------------------------------
module pod_fetch_model (
    input wire logic mclk_i,
    output logic byte_valid_o,
    output logic [7:0] byte_o,
    output logic data_len_8bit_o,
    output logic [7:0] direct_page_base_low_o
);
    initial begin
        byte_valid_o = 1'b0;
        byte_o = 8'h00;
        data_len_8bit_o = 1'b1;
        direct_page_base_low_o = 8'h00;
    end

    task automatic put(input logic [7:0] b, input logic m,
                       input logic [7:0] dpl);
        @(posedge mclk_i);
        #1;
        byte_valid_o = 1'b1;
        byte_o = b;
        data_len_8bit_o = m;
        direct_page_base_low_o = dpl;
    endtask

    // Released lines flip so a stale byte is never mistaken for a new one
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge mclk_i);
            #1;
            byte_valid_o = 1'b0;
            byte_o = ~byte_o;
            data_len_8bit_o = ~data_len_8bit_o;
            direct_page_base_low_o = ~direct_page_base_low_o;
        end
    endtask
endmodule

// *** prefixed_opcode_decoder_test.sv ***
`timescale 1ns/1ps

module prefixed_opcode_decoder_test;
    import pod_pkg::*;
    logic mclk_i, reset_n_i, byte_valid_i, data_len_8bit_i;
    logic [7:0] byte_i, direct_page_base_low_i, opcode_o;
    logic decode_valid_o, acc_b_o, acc_wide_o, extra_cycle_o;
    logic undefined_o, prefix_pending_o;
    pod_map_t map_o;
    pod_op_t op_o;
    pod_mode_t mode_o;
    pod_xfer_t xfer_reg_o;
    int errors = 0;
    int checks = 0;
    int cycles = 0;

    pod_fetch_model fm (.mclk_i(mclk_i), .byte_valid_o(byte_valid_i),
        .byte_o(byte_i), .data_len_8bit_o(data_len_8bit_i),
        .direct_page_base_low_o(direct_page_base_low_i));

    pod_decoder uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .byte_valid_i(byte_valid_i), .byte_i(byte_i),
        .data_len_8bit_i(data_len_8bit_i),
        .direct_page_base_low_i(direct_page_base_low_i),
        .decode_valid_o(decode_valid_o), .opcode_o(opcode_o),
        .map_o(map_o), .op_o(op_o), .mode_o(mode_o),
        .xfer_reg_o(xfer_reg_o), .acc_b_o(acc_b_o),
        .acc_wide_o(acc_wide_o), .extra_cycle_o(extra_cycle_o),
        .undefined_o(undefined_o), .prefix_pending_o(prefix_pending_o));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    // Whole run needs about 130 cycles
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic finish_test;
        if (errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic issue(input logic [8:0] pre, input logic [7:0] b,
                         input logic m, input logic [7:0] dpl);
        if (pre[8]) fm.put(pre[7:0], 1'b1, 8'h00);
        fm.put(b, m, dpl);
        fm.idle(1);
    endtask

    task automatic expect_dec(input pod_map_t mp, input pod_op_t op,
                              input pod_mode_t md, input logic [7:0] opc);
        cmp(decode_valid_o, 1'b1);
        cmp(map_o, mp);
        cmp(op_o, op);
        cmp(mode_o, md);
        cmp(opcode_o, opc);
        cmp(acc_b_o, mp == map_second);
        cmp(undefined_o, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_second;
        logic [7:0] bt [8] = '{8'h8A, 8'hAA, 8'h1B, 8'h7B, 8'h98, 8'hA8,
                               8'h3B, 8'h5B};
        pod_op_t op [8] = '{op_move_to_b, op_move_from_b, op_move_from_b,
            op_move_to_b, op_move_to_b, op_move_from_b, op_move_to_b,
            op_move_from_b};
        pod_xfer_t xf [8] = '{xfer_x, xfer_x, xfer_stack,
            xfer_direct_page_base, xfer_y, xfer_y, xfer_stack,
            xfer_direct_page_base};
        fm.put(PREFIX_SECOND, 1'b1, 8'h00);
        fm.idle(1);
        cmp(prefix_pending_o, 1'b1);
        cmp(decode_valid_o, 1'b0);
        fm.idle(3);
        issue(9'h000, 8'hA9, 1'b1, 8'h00);
        expect_dec(map_second, op_load, mode_imm, 8'hA9);
        cmp(prefix_pending_o, 1'b0);
        fm.put(PREFIX_SECOND, 1'b1, 8'h00);
        fm.put(8'h45, 1'b1, 8'h00);
        cmp(prefix_pending_o, 1'b1);
        fm.idle(1);
        expect_dec(map_second, op_xor, mode_dir, 8'h45);
        issue(9'h142, 8'h48, 1'b1, 8'h00);
        expect_dec(map_second, push_second_acc_op, mode_stk, 8'h48);
        issue(9'h142, 8'h68, 1'b1, 8'h00);
        expect_dec(map_second, pull_second_acc_op, mode_stk, 8'h68);
        for (int i = 0; i < 8; i++) begin
            issue(9'h142, bt[i], 1'b1, 8'h00);
            cmp(op_o, op[i]);
            cmp(xfer_reg_o, xf[i]);
        end
        issue(9'h142, 8'h0A, 1'b0, 8'h00);
        expect_dec(map_second, op_unary_b, mode_acc, 8'h0A);
        cmp(acc_wide_o, 1'b1);
        issue(9'h142, 8'h5A, 1'b1, 8'h00);
        cmp(undefined_o, 1'b1);
        issue(9'h142, 8'h42, 1'b1, 8'h00);
        cmp(undefined_o, 1'b1);
        cmp(map_o, map_second);
    endtask

    task automatic t_third;
        logic [7:0] bt [6] = '{8'h28, 8'h49, 8'hC2, 8'h05, 8'h32, 8'h1F};
        pod_op_t op [6] = '{swap_accumulators_op, rotate_left_by_count_op,
            load_bank_immediate_op, multiply_op, divide_op, multiply_op};
        pod_mode_t md [6] = '{mode_imp, mode_imm, mode_imm, mode_dir,
                              mode_ind, mode_abl_x};
        for (int i = 0; i < 6; i++) begin
            issue(9'h189, bt[i], 1'b1, 8'h00);
            expect_dec(map_third, op[i], md[i], bt[i]);
        end
        issue(9'h189, 8'h50, 1'b1, 8'h00);
        cmp(undefined_o, 1'b1);
        cmp(map_o, map_third);
        issue(9'h189, 8'h89, 1'b1, 8'h00);
        cmp(undefined_o, 1'b1);
    endtask

    task automatic t_primary;
        logic [7:0] bt [8] = '{8'h44, 8'h54, 8'h24, 8'h34, 8'h2C, 8'h3C,
                               8'hC2, 8'hE2};
        pod_op_t op [8] = '{block_move_down_op, block_move_up_op,
            branch_bits_set_op, branch_bits_clear_op, branch_bits_set_op,
            branch_bits_clear_op, clear_status_bits_op, set_status_bits_op};
        pod_mode_t md [8] = '{mode_blk, mode_blk, mode_dir_bit_rel,
            mode_dir_bit_rel, mode_abs_bit_rel, mode_abs_bit_rel,
            mode_imm, mode_imm};
        for (int i = 0; i < 8; i++) begin
            issue(9'h000, bt[i], 1'b1, 8'h00);
            expect_dec(map_primary, op[i], md[i], bt[i]);
        end
        issue(9'h000, 8'h02, 1'b1, 8'h00);
        cmp(undefined_o, 1'b1);
        fm.idle(1);
        cmp(decode_valid_o, 1'b0);
        issue(9'h000, 8'h00, 1'b1, 8'h00);
        expect_dec(map_primary, op_other, mode_none, 8'h00);
    endtask

    task automatic t_stack;
        logic [8:0] pr [6] = '{9'h000, 9'h000, 9'h142, 9'h142, 9'h189,
                               9'h189};
        logic [7:0] bt [6] = '{8'h03, 8'h13, 8'h23, 8'h33, 8'h03, 8'h33};
        pod_map_t mp [6] = '{map_primary, map_primary, map_second,
                             map_second, map_third, map_third};
        pod_op_t op [6] = '{op_or, op_or, op_and, op_and, multiply_op,
                            divide_op};
        for (int i = 0; i < 6; i++) begin
            issue(pr[i], bt[i], 1'b1, 8'h00);
            expect_dec(mp[i], op[i], i[0] ? mode_sr_ind_y : mode_sr,
                       bt[i]);
        end
    endtask

    task automatic t_width;
        issue(9'h000, 8'h05, 1'b0, 8'h00);
        cmp(acc_wide_o, 1'b1);
        cmp(extra_cycle_o, 1'b0);
        issue(9'h000, 8'h05, 1'b1, 8'h01);
        cmp(acc_wide_o, 1'b0);
        cmp(extra_cycle_o, 1'b1);
        issue(9'h000, 8'h0D, 1'b0, 8'hFF);
        cmp(acc_wide_o, 1'b1);
        cmp(extra_cycle_o, 1'b0);
        issue(9'h189, 8'h05, 1'b0, 8'h80);
        cmp(acc_wide_o, 1'b0);
        cmp(extra_cycle_o, 1'b1);
        issue(9'h000, 8'h03, 1'b1, 8'hFF);
        cmp(extra_cycle_o, 1'b0);
    endtask

    task automatic t_reset;
        fm.put(PREFIX_THIRD, 1'b1, 8'h00);
        fm.idle(1);
        cmp(prefix_pending_o, 1'b1);
        reset_n_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        reset_n_i = 1'b1;
        cmp(prefix_pending_o, 1'b0);
        cmp(decode_valid_o, 1'b0);
        issue(9'h000, 8'h05, 1'b1, 8'h00);
        expect_dec(map_primary, op_or, mode_dir, 8'h05);
    endtask

    initial begin
        reset_n_i = 1'b0;
        repeat (6) @(posedge mclk_i);
        #1;
        reset_n_i = 1'b1;
        t_second();
        t_third();
        t_primary();
        t_stack();
        t_width();
        t_reset();
        finish_test();
    end
endmodule
